// ===== rtl/afe_bus_port.sv
`timescale 1ns/100ps
`default_nettype none

module afe_bus_port
  import afe_pkg::*;
(
  input  wire logic         REF_CLK_IN,
  input  wire logic         RESETN_IN,
  input  wire afe_bus_type  TX_BUS_IN,
  input  wire afe_bus_type  RX_BUS_IN,
  input  wire afe_byte_type RX_SAMPLE_IN,
  output afe_regs_type      TX_REGS_OUT,
  output logic              TX_WRITE_PULSE_OUT,
  output logic              AUX_TO_ATTENUATOR_OUT,
  output afe_regs_type      RX_REGS_OUT,
  output logic              RX_WRITE_PULSE_OUT,
  output afe_byte_type      RX_DATA_OUT,
  output logic              RX_DATA_OE_OUT
);

  afe_bus_type      tx_bus;
  afe_bus_type      rx_bus;
  logic             tx_strobe_d_r;
  logic             rx_strobe_d_r;
  logic             tx_selected;
  logic             rx_selected;
  logic             tx_strobe_rise;
  logic             rx_strobe_rise;
  logic             tx_write;
  logic             rx_write;
  logic             rx_read_qual;
  afe_regs_type     tx_regs_r;
  afe_regs_type     rx_regs_r;
  afe_byte_type     rx_data_r;
  afe_byte_type     rx_data_nxt;
  afe_rx_state_type rx_state_r;
  afe_rx_state_type rx_state_nxt;
  logic             rx_oe_r;

  // data rides through the same two stages as the strobe, so byte and edge
  // stay aligned; the host must hold data until the clock that first samples the strobe high
  afe_sync #(
    .WIDTH(BUS_W)
  ) u_tx_sync (
    .clk_in    (REF_CLK_IN),
    .resetn_in (RESETN_IN),
    .async_in  (TX_BUS_IN),
    .sync_out  (tx_bus)
  );

  afe_sync #(
    .WIDTH(BUS_W)
  ) u_rx_sync (
    .clk_in    (REF_CLK_IN),
    .resetn_in (RESETN_IN),
    .async_in  (RX_BUS_IN),
    .sync_out  (rx_bus)
  );

  // delayed strobes reset to their idle low level, so leaving reset fakes no edge
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      tx_strobe_d_r <= STROBE_LOW;
      rx_strobe_d_r <= STROBE_LOW;
    end else begin
      tx_strobe_d_r <= tx_bus.strobe;
      rx_strobe_d_r <= rx_bus.strobe;
    end
  end

  assign tx_selected = (tx_bus.chip_select_low_active == CS_LOW_ACTIVE) &&
                       (tx_bus.chip_select_high_active == CS_HIGH_ACTIVE);
  assign rx_selected = (rx_bus.chip_select_low_active == CS_LOW_ACTIVE) &&
                       (rx_bus.chip_select_high_active == CS_HIGH_ACTIVE);

  assign tx_strobe_rise = (tx_bus.strobe == STROBE_HIGH) &&
                          (tx_strobe_d_r == STROBE_LOW);
  assign rx_strobe_rise = (rx_bus.strobe == STROBE_HIGH) &&
                          (rx_strobe_d_r == STROBE_LOW);

  // read cycles to the transmit side are simply ignored: no driver exists
  assign tx_write = tx_strobe_rise && tx_selected &&
                    (tx_bus.read_not_write == RW_WRITE);

  // transmit registers: slot 0 echo, 1 D/A input, 2 control, 3 address
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        tx_regs_r[i] <= REG_RESET;
      end
    end else if (tx_write) begin
      tx_regs_r[tx_bus.register_select_lines] <= tx_bus.data;
    end
  end

  // the pulse leaves on the same edge that updates the slot
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      TX_WRITE_PULSE_OUT <= 1'b0;
    end else begin
      TX_WRITE_PULSE_OUT <= tx_write;
    end
  end

  assign TX_REGS_OUT           = tx_regs_r;
  assign AUX_TO_ATTENUATOR_OUT = tx_regs_r[SLOT_CONTROL][ROUTE_BIT];

  // receive side: the strobe low qualifies a read, its rising edge a write
  assign rx_read_qual = rx_selected &&
                        (rx_bus.read_not_write == RW_READ) &&
                        (rx_bus.strobe == STROBE_LOW);

  // a write must be armed: selected with write direction seen before the strobe rises
  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      RX_IDLE: begin
        if (rx_read_qual) begin
          rx_state_nxt = RX_READ;
        end else if (rx_selected && (rx_bus.read_not_write == RW_WRITE)) begin
          rx_state_nxt = RX_WRITE;
        end
      end
      RX_READ: begin
        if (!rx_read_qual) begin
          rx_state_nxt = RX_IDLE;
        end
      end
      RX_WRITE: begin
        if (!rx_selected || (rx_bus.read_not_write == RW_READ)) begin
          rx_state_nxt = RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      rx_state_r <= RX_IDLE;
    end else begin
      rx_state_r <= rx_state_nxt;
    end
  end

  assign rx_write = (rx_state_r == RX_WRITE) && rx_strobe_rise && rx_selected &&
                    (rx_bus.read_not_write == RW_WRITE);

  // limitation: a write to slot 0 is kept, but reads of slot 0 return the live sample
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        rx_regs_r[i] <= REG_RESET;
      end
    end else if (rx_write) begin
      rx_regs_r[rx_bus.register_select_lines] <= rx_bus.data;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      RX_WRITE_PULSE_OUT <= 1'b0;
    end else begin
      RX_WRITE_PULSE_OUT <= rx_write;
    end
  end

  assign RX_REGS_OUT = rx_regs_r;

  // slot 0 reads the live converter sample; the others read back what was written
  always_comb begin
    rx_data_nxt = rx_data_r;
    if (rx_read_qual) begin
      if (rx_bus.register_select_lines == SLOT_ECHO) begin
        rx_data_nxt = RX_SAMPLE_IN;
      end else begin
        rx_data_nxt = rx_regs_r[rx_bus.register_select_lines];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      rx_data_r <= REG_RESET;
    end else begin
      rx_data_r <= rx_data_nxt;
    end
  end

  assign RX_DATA_OUT    = rx_data_r;

  // drive only while a qualified read is held, so bus turnaround stays clean;
  // taken from a flop so the pin enable cannot glitch while state bits settle
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      rx_oe_r <= 1'b0;
    end else begin
      rx_oe_r <= (rx_state_nxt == RX_READ);
    end
  end

  assign RX_DATA_OE_OUT = rx_oe_r;

endmodule

`default_nettype wire

// ===== rtl/afe_pkg.sv
package afe_pkg;

  localparam int DATA_W    = 8;
  localparam int RS_W      = 2;
  localparam int NUM_SLOTS = 4;

  // register slots reached through the two register-select lines
  localparam logic [RS_W-1:0] SLOT_ECHO    = 2'h0;
  localparam logic [RS_W-1:0] SLOT_DA      = 2'h1;
  localparam logic [RS_W-1:0] SLOT_CONTROL = 2'h2;
  localparam logic [RS_W-1:0] SLOT_ADDRESS = 2'h3;

  // control bit that steers the auxiliary analog input
  localparam int ROUTE_BIT = 4;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // pin levels
  localparam logic RW_WRITE       = 1'b0;
  localparam logic RW_READ        = 1'b1;
  localparam logic CS_LOW_ACTIVE  = 1'b0;
  localparam logic CS_HIGH_ACTIVE = 1'b1;
  localparam logic STROBE_LOW     = 1'b0;
  localparam logic STROBE_HIGH    = 1'b1;

  typedef logic [DATA_W-1:0] afe_byte_type;

  typedef afe_byte_type [NUM_SLOTS-1:0] afe_regs_type;

  typedef struct packed {
    logic              strobe;
    logic              read_not_write;
    logic              chip_select_low_active;
    logic              chip_select_high_active;
    logic [RS_W-1:0]   register_select_lines;
    logic [DATA_W-1:0] data;
  } afe_bus_type;

  localparam int BUS_W = $bits(afe_bus_type);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_READ,
    RX_WRITE
  } afe_rx_state_type;

endpackage

// ===== rtl/afe_sync.sv
`timescale 1ns/100ps
`default_nettype none

module afe_sync
  import afe_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ===== tb/afe_bus_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module afe_bus_port_asserts
  import afe_pkg::*;
(
  input wire logic         REF_CLK_IN,
  input wire logic         RESETN_IN,
  input wire afe_bus_type  TX_BUS_IN,
  input wire afe_bus_type  RX_BUS_IN,
  input wire afe_byte_type RX_SAMPLE_IN,
  input wire afe_regs_type TX_REGS_OUT,
  input wire logic         TX_WRITE_PULSE_OUT,
  input wire logic         AUX_TO_ATTENUATOR_OUT,
  input wire afe_regs_type RX_REGS_OUT,
  input wire logic         RX_WRITE_PULSE_OUT,
  input wire afe_byte_type RX_DATA_OUT,
  input wire logic         RX_DATA_OE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  wire tx_w = TX_BUS_IN.strobe && !TX_BUS_IN.read_not_write
    && !TX_BUS_IN.chip_select_low_active && TX_BUS_IN.chip_select_high_active;
  wire rx_s = !RX_BUS_IN.chip_select_low_active && RX_BUS_IN.chip_select_high_active;
  wire rx_w = rx_s && RX_BUS_IN.strobe && !RX_BUS_IN.read_not_write;
  wire rx_r = rx_s && !RX_BUS_IN.strobe && RX_BUS_IN.read_not_write;
  // two sync flops and the pulse flop put the pin edge three samples back
  tx_cause_a: assert property (
    TX_WRITE_PULSE_OUT |-> $past(tx_w, 3) && !$past(TX_BUS_IN.strobe, 4))
    else $error("tx pulse without strobe rise");
  tx_store_a: assert property (
    TX_WRITE_PULSE_OUT |-> TX_REGS_OUT[$past(TX_BUS_IN.register_select_lines, 3)]
      == $past(TX_BUS_IN.data, 3)) else $error("tx byte in wrong slot");
  tx_hold_a: assert property ($changed(TX_REGS_OUT) |-> TX_WRITE_PULSE_OUT)
    else $error("tx slot changed without write");
  aux_route_a: assert property (
    TX_WRITE_PULSE_OUT && ($past(TX_BUS_IN.register_select_lines, 3) == SLOT_CONTROL)
      |-> AUX_TO_ATTENUATOR_OUT == $past(TX_BUS_IN.data[ROUTE_BIT], 3))
    else $error("aux route differs from control");
  rx_cause_a: assert property (
    RX_WRITE_PULSE_OUT |-> $past(rx_w, 3) && !$past(RX_BUS_IN.strobe, 4))
    else $error("rx pulse without strobe rise");
  rx_hold_a: assert property ($changed(RX_REGS_OUT) |-> RX_WRITE_PULSE_OUT)
    else $error("rx slot changed without write");
  oe_timing_a: assert property (RX_DATA_OE_OUT == $past(rx_r, 3))
    else $error("rx drive window wrong");
  rd_data_a: assert property (RX_DATA_OE_OUT |-> RX_DATA_OUT ==
    (($past(RX_BUS_IN.register_select_lines, 3) == SLOT_ECHO) ? $past(RX_SAMPLE_IN)
      : RX_REGS_OUT[$past(RX_BUS_IN.register_select_lines, 3)])) else $error("rx read data");
  cover property (TX_WRITE_PULSE_OUT);
  cover property (RX_WRITE_PULSE_OUT);
  cover property (RX_DATA_OE_OUT);
endmodule
bind afe_bus_port afe_bus_port_asserts chk (.*);
`default_nettype wire

// ===== tb/afe_host.sv
`timescale 1ns/100ps
`default_nettype none
module afe_host
  import afe_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         dev_oe_in,
  input  wire afe_byte_type dev_data_in,
  output afe_bus_type       tx_bus_out,
  output afe_bus_type       rx_bus_out
);
  afe_bus_type b;
  afe_bus_type idle;
  logic        rx_n;
  logic        host_oe;
  logic        wait_expired;
  initial begin
    b = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 8'h00};
    rx_n = 1'b0;
    host_oe = 1'b0;
    wait_expired = 1'b0;
  end
  // the chip not addressed sees a deselected bus and a toggled data pattern
  always_comb begin
    idle = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h3, ~b.data};
    tx_bus_out = rx_n ? idle : b;
    rx_bus_out = rx_n ? b : idle;
    rx_bus_out.data = dev_oe_in ? dev_data_in : (rx_n && host_oe) ? b.data : ~b.data;
  end
  task automatic cycle(input logic rx, rw, up, sel, input logic [1:0] rs,
                       input afe_byte_type d, output afe_byte_type q);
    int n;
    @(posedge clk_in);
    #1;
    rx_n = rx;
    b = '{1'b0, rw, 1'b0, sel, rs, d};
    host_oe = !rw;
    repeat (2) @(posedge clk_in);
    #1;
    q = 8'h00;
    if (up) begin
      b.strobe = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      b.strobe = 1'b0;
    end else begin
      n = 0;
      while (!dev_oe_in && n < 8) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      wait_expired = !dev_oe_in;
      q = rx_n ? rx_bus_out.data : ~d;
    end
    b.chip_select_low_active = 1'b1;
    b.chip_select_high_active = 1'b0;
    host_oe = 1'b0;
    repeat (3) @(posedge clk_in);
    // step off the edge so callers look at settled outputs
    #1;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import afe_pkg::*;
;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  afe_bus_type  txb;
  afe_bus_type  rxb;
  afe_byte_type smp = 8'h5C;
  afe_regs_type txr;
  afe_regs_type rxr;
  afe_byte_type rxd;
  logic         txp;
  logic         aux;
  logic         rxp;
  logic         oe;
  afe_byte_type q;
  int           num_errors = 0;
  int           cmp_count = 0;
  // stands in for the master clock that the system supplies
  always #20 clk = ~clk;
  afe_bus_port dut (.REF_CLK_IN(clk), .RESETN_IN(rstn), .TX_BUS_IN(txb), .RX_BUS_IN(rxb),
    .RX_SAMPLE_IN(smp), .TX_REGS_OUT(txr), .TX_WRITE_PULSE_OUT(txp),
    .AUX_TO_ATTENUATOR_OUT(aux), .RX_REGS_OUT(rxr), .RX_WRITE_PULSE_OUT(rxp),
    .RX_DATA_OUT(rxd), .RX_DATA_OE_OUT(oe));
  afe_host host (.clk_in(clk), .dev_oe_in(oe), .dev_data_in(rxd), .tx_bus_out(txb),
    .rx_bus_out(rxb));
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic sc_tx;
    for (int s = 0; s < 4; s++) begin
      host.cycle(1'b0, 1'b0, 1'b1, 1'b1, 2'(s), 8'(8'hA4 + s), q);
      chk("tx_slot", txr[s], 8'(8'hA4 + s));
    end
    host.cycle(1'b0, 1'b0, 1'b1, 1'b1, SLOT_CONTROL, 8'h10, q);
    chk("aux_on", {7'h00, aux}, 8'h01);
    host.cycle(1'b0, 1'b0, 1'b1, 1'b1, SLOT_CONTROL, 8'hEF, q);
    chk("aux_off", {7'h00, aux}, 8'h00);
  endtask
  task automatic sc_refuse;
    host.cycle(1'b0, 1'b1, 1'b1, 1'b1, SLOT_ECHO, 8'h3E, q);
    host.cycle(1'b0, 1'b0, 1'b1, 1'b0, SLOT_DA, 8'h3E, q);
    host.cycle(1'b1, 1'b0, 1'b1, 1'b0, SLOT_DA, 8'h3E, q);
    chk("tx_rw_high", txr[0], 8'hA4);
    chk("tx_desel", txr[1], 8'hA5);
    chk("rx_desel", rxr[1], 8'h00);
  endtask
  task automatic sc_rx;
    for (int s = 1; s < 4; s++) begin
      host.cycle(1'b1, 1'b0, 1'b1, 1'b1, 2'(s), 8'(8'h61 * s), q);
      chk("rx_slot", rxr[s], 8'(8'h61 * s));
    end
    for (int s = 0; s < 4; s++) begin
      host.cycle(1'b1, 1'b1, 1'b0, 1'b1, 2'(s), 8'h00, q);
      chk("rx_wait", {7'h00, host.wait_expired}, 8'h00);
      chk("rx_read", q, (s == 0) ? smp : 8'(8'h61 * s));
      chk("rx_release", {7'h00, oe}, 8'h00);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("reset_aux", {7'h00, aux}, 8'h00);
    sc_tx();
    sc_refuse();
    sc_rx();
    end_sim();
  end
endmodule
`default_nettype wire
